// *** rtl/dac_input_word_register_decode.sv ***
// decoder of framed 24/32-bit input words into channel registers
// What this block does
// - word is 24 bits MSB first: rw, dev sel, reg sel, ch sel, payload
// - act only when device select equals the two hardware address pins
// - reg select 000 writes the addressed channel data register
// - reg select 110 writes the addressed channel clear value
// - reg select 111 routes the word to the control register path
// - channel select 00..11 picks A..D, ignored for broadcast writes
// - channel data sits in the low sixteen bits of the word
// - sixteen bit gain per channel, reg select 010 writes one
// - reg select 011 writes the gain of all four channels
// - gain is unsigned and resets to all ones
// - sixteen bit offset per channel, reg select 100 writes one
// - reg select 101 writes the offset of all four channels
// - offset resets to midscale, meaning no adjustment
// - clear value resets to zero, output for use on asynchronous clear
// - each channel's response to clear has a software enable
// - control writes carry a 3-bit control select below channel select
`timescale 1ns/10ps
module dac_input_word_register_decode
    import word_decode_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        word_valid_i,
    input  wire logic [31:0] word_i,
    input  wire logic        packet_check_extension_i,
    input  wire logic        hw_address_pin1_i,
    input  wire logic        hw_address_pin0_i,
    input  wire logic [3:0]  clear_enable_i,
    input  wire logic        clear_pin_i,
    output logic [15:0]      channel_output_code_o [NUM_CHANNELS],
    output logic [15:0]      channel_gain_trim_o   [NUM_CHANNELS],
    output logic [15:0]      channel_offset_trim_o [NUM_CHANNELS],
    output logic [15:0]      channel_clear_value_o [NUM_CHANNELS],
    output logic [3:0]       channel_cleared_o,
    output logic             ctrl_write_o,
    output logic [2:0]       control_select_field_o,
    output logic [1:0]       ctrl_channel_o,
    output logic [12:0]      ctrl_payload_o
);

    ////////////////////////////////////////////////////////////////////
    word_write_if wr ();

    logic [23:0] w;
    logic [2:0]  addr_s1_r;
    logic [2:0]  addr_s2_r;
    logic [2:0]  addr_s3_r;
    logic [1:0]  addr_r;
    logic [1:0]  dev_sel;
    logic [2:0]  reg_sel;
    logic [1:0]  channel_select;
    logic        device_hit;
    logic        is_write;

    // with check extension the trailing byte is the crc, word sits above
    assign w = packet_check_extension_i ? word_i[31:8] : word_i[23:0];

    ////////////////////////////////////////////////////////////////////
    // address pins and clear pin are asynchronous: three-stage sampling
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            addr_s1_r <= 3'h0;
            addr_s2_r <= 3'h0;
            addr_s3_r <= 3'h0;
            addr_r    <= 2'h0;
        end else begin
            addr_s1_r <= {clear_pin_i, hw_address_pin1_i, hw_address_pin0_i};
            addr_s2_r <= addr_s1_r;
            addr_s3_r <= addr_s2_r;
            if (addr_s2_r[1:0] == addr_s3_r[1:0]) begin
                addr_r <= addr_s3_r[1:0];
            end
        end
    end

    logic clear_lvl_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            clear_lvl_r <= 1'b0;
        end else if (addr_s2_r[2] == addr_s3_r[2]) begin
            clear_lvl_r <= addr_s3_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign dev_sel          = w[DEV_SEL_LSB +: 2];
    assign reg_sel          = w[REG_SEL_LSB +: 3];
    assign channel_select   = w[CH_SEL_LSB +: 2];
    assign device_hit       = (dev_sel == addr_r);
    // rw low means write; reads are outside this block
    assign is_write         = word_valid_i && !w[RW_POS] && device_hit;

    always_comb begin
        wr.wr_data   = 1'b0;
        wr.wr_gain   = 1'b0;
        wr.wr_offset = 1'b0;
        wr.wr_clear  = 1'b0;
        wr.broadcast = 1'b0;
        wr.channel   = channel_select;
        wr.payload   = w[PAYLOAD_BITS-1:0];
        if (is_write) begin
            unique case (reg_sel)
                REG_DATA:       wr.wr_data = 1'b1;
                REG_GAIN:       wr.wr_gain = 1'b1;
                REG_GAIN_ALL: begin
                    wr.wr_gain   = 1'b1;
                    wr.broadcast = 1'b1;
                end
                REG_OFFSET:     wr.wr_offset = 1'b1;
                REG_OFFSET_ALL: begin
                    wr.wr_offset = 1'b1;
                    wr.broadcast = 1'b1;
                end
                REG_CLEAR:      wr.wr_clear = 1'b1;
                default: ;
            endcase
        end
    end

    channel_reg_store u_store (
        .clk_i    (clk_i),
        .srst_i   (srst_i),
        .wr       (wr.sink),
        .data_o   (channel_output_code_o),
        .gain_o   (channel_gain_trim_o),
        .offset_o (channel_offset_trim_o),
        .clear_o  (channel_clear_value_o)
    );

    ////////////////////////////////////////////////////////////////////
    // control register path: handed out for a separate sub-decoder
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_write_o           <= 1'b0;
            control_select_field_o <= 3'h0;
            ctrl_channel_o         <= 2'h0;
            ctrl_payload_o         <= 13'h0000;
        end else begin
            ctrl_write_o <= is_write && (reg_sel == REG_CONTROL);
            if (is_write && (reg_sel == REG_CONTROL)) begin
                control_select_field_o <= w[CTRL_SEL_LSB +: 3];
                ctrl_channel_o         <= channel_select;
                ctrl_payload_o         <= w[12:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-channel clear response, gated by software enable
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            channel_cleared_o <= 4'h0;
        end else begin
            channel_cleared_o <= {4{clear_lvl_r}} & clear_enable_i;
        end
    end

endmodule

// *** rtl/word_decode_pkg.sv ***
// shared constants for the dac input word decoder
package word_decode_pkg;
    localparam int WORD_BITS      = 24;
    localparam int WORD_PEC_BITS  = 32;
    localparam int PAYLOAD_BITS   = 16;
    localparam int NUM_CHANNELS   = 4;
    // field positions inside the 24-bit word
    localparam int RW_POS         = 23;
    localparam int DEV_SEL_LSB    = 21;
    localparam int REG_SEL_LSB    = 18;
    localparam int CH_SEL_LSB     = 16;
    localparam int CTRL_SEL_LSB   = 13;
    // reg_select_field codes
    localparam logic [2:0] REG_DATA        = 3'h0;
    localparam logic [2:0] REG_GAIN        = 3'h2;
    localparam logic [2:0] REG_GAIN_ALL    = 3'h3;
    localparam logic [2:0] REG_OFFSET      = 3'h4;
    localparam logic [2:0] REG_OFFSET_ALL  = 3'h5;
    localparam logic [2:0] REG_CLEAR       = 3'h6;
    localparam logic [2:0] REG_CONTROL     = 3'h7;
    // reset values
    localparam logic [15:0] DATA_RST   = 16'h0000;
    localparam logic [15:0] GAIN_RST   = 16'hffff;
    localparam logic [15:0] OFFSET_RST = 16'h8000;
    localparam logic [15:0] CLEAR_RST  = 16'h0000;
endpackage

// *** rtl/word_write_if.sv ***
// write strobe bundle between decoder and channel register store
`timescale 1ns/10ps
interface word_write_if;
    logic        wr_data;
    logic        wr_gain;
    logic        wr_offset;
    logic        wr_clear;
    logic        broadcast;
    logic [1:0]  channel;
    logic [15:0] payload;
    modport source (output wr_data, wr_gain, wr_offset, wr_clear,
                    output broadcast, channel, payload);
    modport sink   (input wr_data, wr_gain, wr_offset, wr_clear,
                    input broadcast, channel, payload);
endinterface

// *** rtl/channel_reg_store.sv ***
// per-channel data, gain, offset and clear value registers
`timescale 1ns/10ps
module channel_reg_store
    import word_decode_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    word_write_if.sink       wr,
    output logic [15:0]      data_o   [NUM_CHANNELS],
    output logic [15:0]      gain_o   [NUM_CHANNELS],
    output logic [15:0]      offset_o [NUM_CHANNELS],
    output logic [15:0]      clear_o  [NUM_CHANNELS]
);

    function automatic logic hit(input logic [1:0] ch, input int idx,
                                 input logic bc);
        hit = bc || (ch == idx[1:0]);
    endfunction

    for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_ch
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                data_o[c]   <= DATA_RST;
                gain_o[c]   <= GAIN_RST;
                offset_o[c] <= OFFSET_RST;
                clear_o[c]  <= CLEAR_RST;
            end else begin
                if (wr.wr_data && hit(wr.channel, c, 1'b0)) begin
                    data_o[c] <= wr.payload;
                end
                if (wr.wr_gain && hit(wr.channel, c, wr.broadcast)) begin
                    gain_o[c] <= wr.payload;
                end
                if (wr.wr_offset && hit(wr.channel, c, wr.broadcast)) begin
                    offset_o[c] <= wr.payload;
                end
                if (wr.wr_clear && hit(wr.channel, c, 1'b0)) begin
                    clear_o[c] <= wr.payload;
                end
            end
        end
    end
endmodule

// *** verification/word_decode_monitor.sv ***
// assertion checker on the input word decoder ports
`timescale 1ns/10ps
module word_decode_monitor
    import word_decode_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        word_valid_i,
    input wire logic [31:0] word_i,
    input wire logic        packet_check_extension_i,
    input wire logic        hw_address_pin1_i,
    input wire logic        hw_address_pin0_i,
    input wire logic [15:0] channel_output_code_o [NUM_CHANNELS],
    input wire logic [15:0] channel_gain_trim_o   [NUM_CHANNELS],
    input wire logic [15:0] channel_offset_trim_o [NUM_CHANNELS],
    input wire logic [15:0] channel_clear_value_o [NUM_CHANNELS],
    input wire logic        ctrl_write_o,
    input wire logic [2:0]  control_select_field_o,
    input wire logic [12:0] ctrl_payload_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    wire  [23:0] w = packet_check_extension_i ? word_i[31:8] : word_i[23:0];
    wire  [1:0]  pins = {hw_address_pin1_i, hw_address_pin0_i};
    wire  [2:0]  rs = w[20:18];
    logic [1:0]  pin_r;
    logic [2:0]  quiet_r;
    logic [1:0]  ch_r;
    logic [15:0] pl_r;
    // only judge words once the pin synchroniser has surely settled
    wire go = word_valid_i && !w[23] && w[22:21] == pins && quiet_r == 3'h7;
    always_ff @(posedge clk_i) begin
        pin_r <= pins;
        ch_r <= w[17:16];
        pl_r <= w[15:0];
    end
    always_ff @(posedge clk_i) begin
        if (srst_i || pin_r != pins) begin
            quiet_r <= 3'h0;
        end else if (quiet_r != 3'h7) begin
            quiet_r <= quiet_r + 3'h1;
        end
    end
    function automatic bit all4(input logic [15:0] a [4],
                                input logic [15:0] v);
        return a[0] == v && a[1] == v && a[2] == v && a[3] == v;
    endfunction
    data_one_a: assert property (go && rs == REG_DATA |=>
        channel_output_code_o[ch_r] == pl_r) else $error("data write lost");
    gain_one_a: assert property (go && rs == REG_GAIN |=>
        channel_gain_trim_o[ch_r] == pl_r) else $error("gain write lost");
    gain_all_a: assert property (go && rs == REG_GAIN_ALL |=>
        all4(channel_gain_trim_o, pl_r)) else $error("gain broadcast lost");
    offset_one_a: assert property (go && rs == REG_OFFSET |=>
        channel_offset_trim_o[ch_r] == pl_r) else $error("offset write lost");
    offset_all_a: assert property (go && rs == REG_OFFSET_ALL |=>
        all4(channel_offset_trim_o, pl_r)) else $error("offset bcast lost");
    clear_one_a: assert property (go && rs == REG_CLEAR |=>
        channel_clear_value_o[ch_r] == pl_r) else $error("clear write lost");
    ctrl_path_a: assert property (go && rs == REG_CONTROL |=>
        ctrl_write_o && control_select_field_o == $past(w[15:13])
        && ctrl_payload_o == $past(w[12:0])) else $error("control lost");
    ctrl_only_a: assert property (ctrl_write_o |->
        $past(word_valid_i && !w[23] && rs == REG_CONTROL))
        else $error("stray control write");
    reset_vals_a: assert property ($fell(srst_i) |->
        all4(channel_gain_trim_o, GAIN_RST) && all4(channel_offset_trim_o,
        OFFSET_RST) && all4(channel_clear_value_o, CLEAR_RST))
        else $error("bad reset value");
    cover property (go && rs == REG_GAIN_ALL);
    cover property (go && rs == REG_CONTROL);
    cover property (word_valid_i && w[23]);
endmodule

// *** verification/word_host_model.sv ***
// host controller model issuing framed write words
`timescale 1ns/10ps
module word_host_model (
    input  wire logic        clk_i,
    output logic             valid_o,
    output logic [31:0]      word_o,
    output logic             pec_o
);
    initial begin
        valid_o = 1'b0;
        word_o = 32'h0;
        pec_o = 1'b0;
    end
    // called right after an edge; held through the taking edge
    task automatic send(input logic [23:0] w, input logic packet_check_extension);
        valid_o = 1'b1;
        pec_o = packet_check_extension;
        word_o = packet_check_extension ? {w, 8'h3c} : {8'ha5, w};
        @(posedge clk_i);
        #1;
    endtask
    // a released line shows the inverse, never the stale word
    task automatic idle();
        valid_o = 1'b0;
        word_o = ~word_o;
    endtask
endmodule

// *** verification/dac_input_word_register_decode_test.sv ***
// self-checking bench for the input word decoder
`timescale 1ns/10ps
module dac_input_word_register_decode_test;
    import word_decode_pkg::*;
    typedef struct packed {logic [23:0] w; logic p;} row_s;
    logic        clk_i, srst_i, word_valid_i, packet_check_extension_i;
    logic        hw_address_pin1_i, hw_address_pin0_i, clear_pin_i;
    logic [31:0] word_i;
    logic [3:0]  clear_enable_i, channel_cleared_o;
    logic [15:0] channel_output_code_o [4], channel_gain_trim_o [4];
    logic [15:0] channel_offset_trim_o [4], channel_clear_value_o [4];
    logic [15:0] e [4][4];
    logic        ctrl_write_o;
    logic [2:0]  control_select_field_o;
    logic [12:0] ctrl_payload_o;
    logic [1:0]  ctrl_channel_o;
    int          err_total, cmp_count;
    row_s rows [10] = '{'{24'h421234, 0}, '{24'h490001, 1}, '{24'h4faaaa, 0},
        '{24'h500000, 0}, '{24'h54ffff, 1}, '{24'h5b5a5a, 0}, '{24'hc21111, 0},
        '{24'h222222, 0}, '{24'h453333, 0}, '{24'h4a7fff, 0}};
    dac_input_word_register_decode dut (.clk_i, .srst_i, .word_valid_i,
        .word_i, .packet_check_extension_i, .hw_address_pin1_i,
        .hw_address_pin0_i, .clear_enable_i, .clear_pin_i,
        .channel_output_code_o, .channel_gain_trim_o, .channel_offset_trim_o,
        .channel_clear_value_o, .channel_cleared_o, .ctrl_write_o,
        .control_select_field_o, .ctrl_channel_o, .ctrl_payload_o);
    word_host_model host (.clk_i, .valid_o(word_valid_i), .word_o(word_i),
        .pec_o(packet_check_extension_i));
    ////////////////////////////////////////////////////////////////////////
    task automatic apply(input logic [23:0] w);
        if (!w[23] && w[22:21] == {hw_address_pin1_i, hw_address_pin0_i}) begin
            case (w[20:18])
                REG_DATA:       e[0][w[17:16]] = w[15:0];
                REG_GAIN:       e[1][w[17:16]] = w[15:0];
                REG_GAIN_ALL:   e[1] = '{4{w[15:0]}};
                REG_OFFSET:     e[2][w[17:16]] = w[15:0];
                REG_OFFSET_ALL: e[2] = '{4{w[15:0]}};
                REG_CLEAR:      e[3][w[17:16]] = w[15:0];
                default: ;
            endcase
        end
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_all();
        for (int c = 0; c < 4; c++) begin
            chk(channel_output_code_o[c], e[0][c]);
            chk(channel_gain_trim_o[c], e[1][c]);
            chk(channel_offset_trim_o[c], e[2][c]);
            chk(channel_clear_value_o[c], e[3][c]);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        #20000;
        err_total++;
        summarize();
    end
    initial begin
        // pins 10: the 0x4x/0x5x rows hit, 0x22 row is refused
        {srst_i, hw_address_pin1_i, hw_address_pin0_i, clear_pin_i} = 4'hc;
        clear_enable_i = 4'h5;
        e = '{'{4{DATA_RST}}, '{4{GAIN_RST}}, '{4{OFFSET_RST}}, '{4{CLEAR_RST}}};
        repeat (8) @(posedge clk_i);
        #1 srst_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #1 chk_all();
        foreach (rows[i]) begin
            host.send(rows[i].w, rows[i].p);
            apply(rows[i].w);
            chk_all();
        end
        host.send(24'h5de001, 1'b0);
        chk(16'(ctrl_write_o), 16'h1);
        chk(16'(ctrl_channel_o), 16'h1);
        chk(16'(control_select_field_o), 16'h7);
        chk(16'(ctrl_payload_o), 16'h1);
        chk_all();
        host.idle();
        {hw_address_pin1_i, hw_address_pin0_i, clear_pin_i} = 3'h3;
        repeat (6) @(posedge clk_i);
        #1 chk(16'(channel_cleared_o), 16'h5);
        host.send(24'h222222, 1'b0);
        apply(24'h222222);
        host.idle();
        chk_all();
        srst_i = 1'b1;
        @(posedge clk_i);
        #1 srst_i = 1'b0;
        e = '{'{4{DATA_RST}}, '{4{GAIN_RST}}, '{4{OFFSET_RST}}, '{4{CLEAR_RST}}};
        chk_all();
        summarize();
    end
endmodule
bind dac_input_word_register_decode word_decode_monitor mon (.clk_i,
    .srst_i, .word_valid_i, .word_i, .packet_check_extension_i,
    .hw_address_pin1_i, .hw_address_pin0_i, .channel_output_code_o,
    .channel_gain_trim_o, .channel_offset_trim_o, .channel_clear_value_o,
    .ctrl_write_o, .control_select_field_o, .ctrl_payload_o);
